// [dv/switch_policy_assertions.sv]
// Purpose: Concurrent checks on the ports of the ingress policy bank
// Assumes: One clock domain with an asynchronous active-low reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module switch_policy_checker #(
  parameter int unsigned INTERVAL_CYCLES =
    switch_policy_pkg::BCAST_INTERVAL_CYCLES
) (
  input wire logic                        clock,     // Core clock
  input wire logic                        rstn,      // Reset, active low
  input switch_policy_pkg::bus_req_t      bus,       // Register request
  input wire logic [31:0]                 rdata,     // Read data
  input switch_policy_pkg::pkt_desc_t     pkt,       // Received packet
  input switch_policy_pkg::tx_event_t     tx,        // Transmitted packet
  input switch_policy_pkg::fwd_decision_t decision,  // Ingress decision
  input switch_policy_pkg::tx_mirror_t    tx_mirror, // Transmit copy
  input wire logic                        irq        // Interrupt
);
  import switch_policy_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_red_metered;
    pkt.valid && pkt.meter_red ##1 decision.meter_on;
  endsequence
  property p_dec_follow;
    pkt.valid |=> decision.valid;
  endproperty
  property p_dec_alone;
    !pkt.valid |=> !decision.valid && decision.mirror == 3'h0;
  endproperty
  property p_drop_dest;
    decision.valid && decision.drop |-> decision.dest == 3'h0 &&
      decision.filtered_count == (3'h1 << decision.src_port);
  endproperty
  property p_filtered;
    pkt.valid && pkt.filtered |=> decision.drop;
  endproperty
  property p_tag;
    decision.valid && !decision.drop && decision.tag_directed |->
      decision.dest == $past(pkt.tag_dest);
  endproperty
  property p_plain;
    decision.valid && !decision.drop && !decision.tag_directed |->
      decision.dest == $past(pkt.dest);
  endproperty
  property p_meter;
    s_red_metered |-> decision.drop;
  endproperty
  property p_meter_off;
    !decision.meter_on |-> decision.meter_index == 5'h0;
  endproperty
  property p_throttle;
    decision.bcast_throttled |-> decision.drop && $past(pkt.bcast);
  endproperty
  property p_tx_cause;
    tx_mirror.valid |-> $past(tx.valid);
  endproperty
  property p_nonmember;
    pkt.valid && pkt.non_member && !pkt.vlan_active |=> decision.drop;
  endproperty

  a_dec_follow: assert property (p_dec_follow)
    else $error("decision missing after packet");
  a_dec_alone: assert property (p_dec_alone)
    else $error("decision or mirror without packet");
  a_drop_dest: assert property (p_drop_dest)
    else $error("dropped packet kept a destination");
  a_filtered: assert property (p_filtered)
    else $error("filtered packet not dropped");
  a_tag: assert property (p_tag)
    else $error("tag mode destination wrong");
  a_plain: assert property (p_plain)
    else $error("normal destination altered");
  a_meter: assert property (p_meter)
    else $error("red packet passed the meter");
  a_meter_off: assert property (p_meter_off)
    else $error("meter index set while metering off");
  a_throttle: assert property (p_throttle)
    else $error("throttle mark without broadcast drop");
  a_tx_cause: assert property (p_tx_cause)
    else $error("transmit copy without transmit");
  a_nonmember: assert property (p_nonmember)
    else $error("non-member on inactive vlan admitted");
endmodule

bind switch_ingress_policy_regs switch_policy_checker #(
  .INTERVAL_CYCLES(INTERVAL_CYCLES)
) u_checker (
  .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .pkt(pkt),
  .tx(tx), .decision(decision), .tx_mirror(tx_mirror), .irq(irq)
);

// [dv/tb_top.sv]
// Purpose: Self-checking bench of the ingress policy bank
// Assumes: Throttle interval shortened to IVL cycles
// Notes:   A reference model here predicts every decision
`timescale 1ns/1ps
module tb_top;
  import switch_policy_pkg::*;
  localparam int unsigned IVL = 200;
  logic          clock = 1'b0;
  logic          rstn = 1'b0;
  bus_req_t      bus = '0;
  pkt_desc_t     pkt = '0;
  tx_event_t     tx = '0;
  logic [31:0]   rdata;
  fwd_decision_t decision;
  tx_mirror_t    tx_mirror;
  logic          irq;
  int            n_mismatch = 0;
  int            tests_run = 0;
  int            seed = 53765;
  int            cyc = 0;
  logic [8:0]    mir = '0;
  logic [5:0]    typ = '0, msk = '0, sts = '0;
  logic [2:0]    adm = '0, rate = '0;
  logic [26:0]   bt = 27'h0080402;
  logic [13:0]   ix [6] = '{IDX_PORT_MIRROR, IDX_PORT_TYPE,
    IDX_BCAST_THROT, IDX_ADMIT_NONMEM, IDX_RATE_CFG, IDX_IRQ_MASK};
  logic [31:0]   rv [6] = '{32'h0, 32'h0, 32'h0080402, 32'h0, 32'h0, 32'h0};
  logic [31:0]   wm [6] = '{32'h1ff, 32'h3f, 32'h7ffffff, 32'h7, 32'h7,
    32'h3f};

  always #20 clock = ~clock;
  always @(posedge clock) if (rstn) cyc <= cyc + 1;

  switch_ingress_policy_regs #(.INTERVAL_CYCLES(IVL)) dut (
    .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .pkt(pkt),
    .tx(tx), .decision(decision), .tx_mirror(tx_mirror), .irq(irq)
  );

  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cfg;
    wr(ba(IDX_PORT_MIRROR), 32'(mir));
    wr(ba(IDX_PORT_TYPE), 32'(typ));
    wr(ba(IDX_BCAST_THROT), 32'(bt));
    wr(ba(IDX_ADMIT_NONMEM), 32'(adm));
    wr(ba(IDX_RATE_CFG), 32'(rate));
  endtask

  function automatic fwd_decision_t exp_dec(input pkt_desc_t p,
                                            input logic thr);
    fwd_decision_t e;
    int s;
    logic on;
    s = p.src_port;
    on = rate[0] && rate[2:1] != 2'h3;
    e = '0;
    e.valid = 1'b1;
    e.src_port = p.src_port;
    e.tag_directed = typ[2*s +: 2] == 2'h3;
    e.meter_on = on;
    e.drop = p.filtered | thr | (on & p.meter_red) |
      (p.non_member & !(adm[s] & p.vlan_active));
    e.dest = e.drop ? 3'h0 : e.tag_directed ? p.tag_dest : p.dest;
    if (mir[1] && mir[2 + s] && (!e.drop || mir[8]))
      e.mirror = mir[7:5];
    if (on)
      e.meter_index = rate[2:1] == 2'h0 ? {p.src_port, p.prio} :
        rate[2:1] == 2'h1 ? 5'(p.src_port) : 5'(p.prio);
    if (e.drop)
      e.filtered_count = 3'h1 << s;
    e.bcast_throttled = thr;
    return e;
  endfunction

  task automatic send(input pkt_desc_t p, input logic thr);
    fwd_decision_t e;
    e = exp_dec(p, thr);
    @(posedge clock);
    pkt <= p;
    @(posedge clock);
    pkt.valid <= 1'b0;
    if (e.drop)
      sts[p.src_port] = 1'b1;
    if (thr)
      sts[3 + p.src_port] = 1'b1;
    #1 chk("decision", 64'(decision), 64'(e));
    chk("irq", irq, |(sts & msk));
  endtask

  task automatic txev(input logic [1:0] pt);
    logic v;
    v = mir[0] & mir[2 + pt];
    @(posedge clock);
    tx <= '{valid: 1'b1, port: pt};
    @(posedge clock);
    tx.valid <= 1'b0;
    #1 chk("tx_mirror.valid", tx_mirror.valid, v);
    if (v)
      chk("tx_mirror.sniffer", tx_mirror.sniffer, mir[7:5]);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge clock);
    $display("Watchdog expired");
    n_mismatch++;
    test_done;
  end

  initial begin
    logic [31:0] v, r;
    pkt_desc_t   p;
    int          b, i;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(ba(ix[i]), v);
      chk("reset value", v, rv[i]);
      wr(ba(ix[i]), '1);
      rd(ba(ix[i]), v);
      chk("writable bits", v, wm[i]);
      wr(ba(ix[i]), rv[i]);
    end
    wr(16'h6130, '1);
    rd(16'h6130, v);
    chk("unmapped read", v, 32'h0);
    rd(16'h611a, v);
    chk("misaligned read", v, 32'h0);
    msk = 6'h3f;
    wr(ba(IDX_IRQ_MASK), 32'(msk));
    // Random configurations cover every rate mode and tag mode
    for (b = 0; b < 16; b++) begin
      r = $random(seed);
      mir = r[8:0];
      mir[7:5] = 3'h1 << (b % 3);
      typ = b[0] ? 6'h3f : r[14:9];
      adm = r[17:15];
      rate = {2'(b), b < 8 ? 1'b1 : r[18]};
      cfg;
      for (i = 0; i < 20; i++) begin
        r = $random(seed);
        p = r[27:0];
        p.valid = 1'b1;
        p.src_port = r[29:28] == 2'h3 ? 2'(i % 3) : r[29:28];
        p.filtered = &r[31:30];
        send(p, 1'b0);
        txev(p.src_port);
      end
    end
    rd(ba(IDX_IRQ_STATUS), v);
    chk("irq status", v, 32'(sts));
    wr(ba(IDX_IRQ_MASK), 32'h0);
    @(posedge clock);
    #1 chk("irq masked", irq, 1'b0);
    wr(ba(IDX_IRQ_MASK), 32'(msk));
    @(posedge clock);
    #1 chk("irq unmasked", irq, |sts);
    wr(ba(IDX_IRQ_STATUS), 32'(sts));
    sts = '0;
    rd(ba(IDX_IRQ_STATUS), v);
    chk("irq cleared", v, 32'h0);
    chk("irq low", irq, 1'b0);
    // Throttle on port 0 only, budget of two 64-byte units
    mir = '0;
    typ = '0;
    adm = '0;
    rate = '0;
    bt = 27'h0080502;
    cfg;
    p = '0;
    p.valid = 1'b1;
    p.bcast = 1'b1;
    p.dest = 3'h6;
    while (cyc % IVL != 50) @(posedge clock);
    p.len = 11'd64;
    send(p, 1'b0);
    send(p, 1'b0);
    p.len = 11'd1;
    send(p, 1'b1);
    p.src_port = 2'h1;
    p.len = 11'd2000;
    send(p, 1'b0);
    send(p, 1'b0);
    while (cyc % IVL != 50) @(posedge clock);
    p.src_port = 2'h0;
    send(p, 1'b0);
    // Budget is used up; a packet seen in the tick cycle still passes
    while (cyc % IVL != 197) @(posedge clock);
    send(p, 1'b0);
    send(p, 1'b1);
    test_done;
  end
endmodule

// [src/bcast_throttle.sv]
// Purpose: Per-port broadcast byte budget over one throttle interval
// Assumes: tick is a one-cycle pulse that opens each new interval
// Notes:   A packet taken while budget remains may overshoot the budget
`timescale 1ns/1ps
module bcast_throttle (
  input  wire logic        clock,        // Core clock
  input  wire logic        rstn,         // Async reset, active low
  input  wire logic        tick,         // Interval start pulse
  input  wire logic        enable,       // Throttling on for this port
  input  wire logic [7:0]  level,        // Budget in 64-byte units
  input  wire logic        bcast_valid,  // Broadcast packet on this port
  input  wire logic [10:0] len,          // Packet length in bytes
  output logic             exhausted     // Budget used up this interval
);
  import switch_policy_pkg::*;

  logic [15:0] byte_count;
  logic [15:0] allowance;
  logic [15:0] base_count;

  // Budget is level times 64 bytes
  assign allowance = {2'h0, level, 6'h00};
  // A packet in the first cycle of an interval opens the new budget
  assign exhausted = enable && !tick && (byte_count >= allowance);
  assign base_count = tick ? 16'h0000 : byte_count;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      byte_count <= 16'h0000;
    end else if (!enable) begin
      byte_count <= 16'h0000;
    end else if (bcast_valid && (tick || !exhausted)) begin
      byte_count <= 16'(base_count + {5'h00, len});
    end else begin
      byte_count <= base_count;
    end
  end

endmodule

// [src/switch_ingress_policy_regs.sv]
// Purpose: Ingress policy register bank and per-packet policy decision
// Assumes: Packet descriptors and transmit events come from core-clock logic
// Notes:   Decision and mirror outputs follow their input by one cycle
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

// Summary of operation
// - Filtered-mirror bit set: discarded mirrored packets go to sniffer only
// - Mirrored discards still count as filtered and raise the drop flag
// - Three sniffer select bits, one per port, choose the sniffer port
// - Each mirrored-port bit marks one port; several may be set
// - Receive mirroring copies packets from mirrored ports to the sniffer
// - Transmit mirroring copies packets sent on mirrored ports to sniffer
// - Port type 11b takes destination from VLAN tag; other values do not
// - Per-port enable bits turn on broadcast input throttling
// - Budget is level times 64 bytes per 1.72 ms; level resets to two
// - Admit bit lets non-member traffic in when the VLAN is active
// - Rate mode picks port and priority, port only, or priority only
// - Rate enable turns metering and meter drops on unless rate mode is 11b
module switch_ingress_policy_regs #(
  parameter int unsigned INTERVAL_CYCLES =
    switch_policy_pkg::BCAST_INTERVAL_CYCLES
) (
  input  wire logic                      clock,     // Core clock, 25 MHz
  input  wire logic                      rstn,      // Async reset, active low
  input  switch_policy_pkg::bus_req_t    bus,       // Register request
  output logic [31:0]                    rdata,     // Read data, next cycle
  input  switch_policy_pkg::pkt_desc_t   pkt,       // Received packet
  input  switch_policy_pkg::tx_event_t   tx,        // Transmitted packet
  output switch_policy_pkg::fwd_decision_t decision, // Ingress decision
  output switch_policy_pkg::tx_mirror_t  tx_mirror, // Transmit mirror copy
  output logic                           irq        // Interrupt, active high
);
  import switch_policy_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [13:0]       idx);
    reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  function automatic logic [2:0] port_onehot(input logic [1:0] p);
    case (p)
      2'h0:    port_onehot = 3'h1;
      2'h1:    port_onehot = 3'h2;
      2'h2:    port_onehot = 3'h4;
      default: port_onehot = 3'h0;
    endcase
  endfunction

  // Stored configuration and interrupt state
  logic [8:0]       port_mirror_config;
  logic [5:0]       ingress_port_type_config;
  logic [26:0]      broadcast_throttle_config;
  logic [2:0]       admit_non_member_config;
  logic [2:0]       ingress_rate_config;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // Decoded fields
  logic             mirror_filtered;
  logic [2:0]       sniffer_sel;
  logic [2:0]       mirrored_ports;
  logic             rx_mirror_en;
  logic             tx_mirror_en;
  logic [2:0]       tag_mode;
  logic [2:0]       bt_enable;
  logic [2:0]       bt_exhausted;
  logic [2:0]       bt_pkt;
  rate_mode_t       rate_mode;
  logic             rate_enable;

  // Interval timer
  logic [15:0]      interval_count;
  logic             interval_tick;

  // Decision terms
  logic [2:0]       src_mask;
  logic             throttled;
  logic             vlan_reject;
  logic             meter_on;
  logic             meter_drop;
  logic             discard;
  logic             tag_directed;
  logic             rx_mirror_hit;
  logic [4:0]       meter_index;
  fwd_decision_t    next_decision;
  tx_mirror_t       next_tx_mirror;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;
  logic [IRQ_W-1:0] next_irq_status;
  logic [31:0]      next_rdata;

  assign mirror_filtered = port_mirror_config[MIR_FILT_BIT];
  assign sniffer_sel     = port_mirror_config[SNIF_LSB +: 3];
  assign mirrored_ports  = port_mirror_config[MIRP_LSB +: 3];
  assign rx_mirror_en    = port_mirror_config[RX_MIR_BIT];
  assign tx_mirror_en    = port_mirror_config[TX_MIR_BIT];
  assign rate_mode   = rate_mode_t'(ingress_rate_config[RATE_MODE_LSB +: 2]);
  assign rate_enable = ingress_rate_config[RATE_EN_BIT];
  assign src_mask    = port_onehot(pkt.src_port);

  // Free-running interval of 1.72 ms shared by all ports
  assign interval_tick =
    (interval_count == 16'(INTERVAL_CYCLES - 1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interval_count <= 16'h0000;
    end else if (interval_tick) begin
      interval_count <= 16'h0000;
    end else begin
      interval_count <= 16'(interval_count + 16'h0001);
    end
  end

  // Per-port field decode and throttle budget
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign tag_mode[gi] =
        (ingress_port_type_config[PTYPE_W*gi +: PTYPE_W]
         == TAG_DIRECT_MODE);
      assign bt_enable[gi] =
        broadcast_throttle_config[BT_STRIDE*gi + BT_EN_OFS];
      assign bt_pkt[gi] = pkt.valid && pkt.bcast && src_mask[gi];

      bcast_throttle u_throttle (
        .clock       (clock),
        .rstn        (rstn),
        .tick        (interval_tick),
        .enable      (bt_enable[gi]),
        .level       (broadcast_throttle_config[BT_STRIDE*gi +: BT_LEVEL_W]),
        .bcast_valid (bt_pkt[gi]),
        .len         (pkt.len),
        .exhausted   (bt_exhausted[gi])
      );
    end
  endgenerate

  // Ingress decision for the packet presented this cycle
  always_comb begin
    throttled = pkt.bcast && ((src_mask & bt_exhausted) != 3'h0);
    vlan_reject = pkt.non_member &&
                  !(((src_mask & admit_non_member_config) != 3'h0) &&
                    pkt.vlan_active);
    meter_on = rate_enable && (rate_mode != RATE_RESERVED);
    meter_drop = meter_on && pkt.meter_red;
    discard = pkt.filtered || vlan_reject || throttled || meter_drop;
    tag_directed = (src_mask & tag_mode) != 3'h0;
    rx_mirror_hit = rx_mirror_en &&
                    ((src_mask & mirrored_ports) != 3'h0);
    case (rate_mode)
      RATE_PORT_PRIO: meter_index = {pkt.src_port, pkt.prio};
      RATE_PORT_ONLY: meter_index = {3'h0, pkt.src_port};
      RATE_PRIO_ONLY: meter_index = {2'h0, pkt.prio};
      default:        meter_index = 5'h00;
    endcase

    next_decision              = '0;
    next_decision.valid        = pkt.valid;
    next_decision.src_port     = pkt.src_port;
    next_decision.tag_directed = tag_directed;
    next_decision.meter_on     = meter_on;
    next_decision.meter_index  = meter_on ? meter_index : 5'h00;
    next_decision.bcast_throttled = pkt.valid && throttled;
    next_decision.drop         = pkt.valid && discard;
    // Original destinations are chosen without regard to mirroring
    if (pkt.valid && !discard) begin
      next_decision.dest = tag_directed ? pkt.tag_dest : pkt.dest;
    end
    // Mirror copy is a separate mask; a discard reaches the sniffer only with mirror_filtered set
    if (pkt.valid && rx_mirror_hit && (!discard || mirror_filtered)) begin
      next_decision.mirror = sniffer_sel;
    end
    if (pkt.valid && discard) begin
      next_decision.filtered_count = src_mask;
    end

    next_tx_mirror = '0;
    if (tx.valid && tx_mirror_en &&
        ((port_onehot(tx.port) & mirrored_ports) != 3'h0)) begin
      next_tx_mirror.valid   = 1'b1;
      next_tx_mirror.sniffer = sniffer_sel;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      decision  <= '0;
      tx_mirror <= '0;
    end else begin
      decision  <= next_decision;
      tx_mirror <= next_tx_mirror;
    end
  end

  // Configuration writes; reserved bits are never stored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_mirror_config <= RST_PORT_MIRROR;
    end else if (bus.wr && reg_hit(bus.addr, IDX_PORT_MIRROR)) begin
      port_mirror_config <= bus.wdata[8:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ingress_port_type_config <= RST_PORT_TYPE;
    end else if (bus.wr && reg_hit(bus.addr, IDX_PORT_TYPE)) begin
      ingress_port_type_config <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      broadcast_throttle_config <= RST_BCAST_THROT;
    end else if (bus.wr && reg_hit(bus.addr, IDX_BCAST_THROT)) begin
      broadcast_throttle_config <= bus.wdata[26:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      admit_non_member_config <= RST_ADMIT_NONMEM;
    end else if (bus.wr && reg_hit(bus.addr, IDX_ADMIT_NONMEM)) begin
      admit_non_member_config <= bus.wdata[2:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ingress_rate_config <= RST_RATE_CFG;
    end else if (bus.wr && reg_hit(bus.addr, IDX_RATE_CFG)) begin
      ingress_rate_config <= bus.wdata[2:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= RST_IRQ;
    end else if (bus.wr && reg_hit(bus.addr, IDX_IRQ_MASK)) begin
      irq_mask <= bus.wdata[IRQ_W-1:0];
    end
  end

  // Sticky drop and throttle flags; a new event outweighs a clear
  always_comb begin
    irq_events = '0;
    if (pkt.valid && discard) begin
      irq_events[IRQ_DROP_LSB +: 3] = src_mask;
    end
    if (pkt.valid && throttled) begin
      irq_events[IRQ_THROT_LSB +: 3] = src_mask;
    end
    irq_clear = '0;
    if (bus.wr && reg_hit(bus.addr, IDX_IRQ_STATUS)) begin
      irq_clear = bus.wdata[IRQ_W-1:0];
    end
    next_irq_status = (irq_status & ~irq_clear) | irq_events;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= (next_irq_status & irq_mask) != '0;
    end
  end

  // Read path: data stands for the one cycle after the strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      if (reg_hit(bus.addr, IDX_PORT_MIRROR)) begin
        next_rdata = {23'h000000, port_mirror_config};
      end else if (reg_hit(bus.addr, IDX_PORT_TYPE)) begin
        next_rdata = {26'h0000000, ingress_port_type_config};
      end else if (reg_hit(bus.addr, IDX_BCAST_THROT)) begin
        next_rdata = {5'h00, broadcast_throttle_config};
      end else if (reg_hit(bus.addr, IDX_ADMIT_NONMEM)) begin
        next_rdata = {29'h00000000, admit_non_member_config};
      end else if (reg_hit(bus.addr, IDX_RATE_CFG)) begin
        next_rdata = {29'h00000000, ingress_rate_config};
      end else if (reg_hit(bus.addr, IDX_IRQ_STATUS)) begin
        next_rdata = {26'h0000000, irq_status};
      end else if (reg_hit(bus.addr, IDX_IRQ_MASK)) begin
        next_rdata = {26'h0000000, irq_mask};
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// [src/switch_policy_pkg.sv]
// Purpose: Shared constants and carriers of the switch ingress policy bank
// Assumes: Register indices are word indices; byte address is index times 4
// Notes:   Widths of reset values match the storage they load
package switch_policy_pkg;

  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned ADDR_W    = 16;

  // Register indices, byte address = index * 4
  localparam logic [13:0] IDX_PORT_MIRROR  = 14'h1846;
  localparam logic [13:0] IDX_PORT_TYPE    = 14'h1847;
  localparam logic [13:0] IDX_BCAST_THROT  = 14'h1848;
  localparam logic [13:0] IDX_ADMIT_NONMEM = 14'h1849;
  localparam logic [13:0] IDX_RATE_CFG     = 14'h184a;
  localparam logic [13:0] IDX_IRQ_STATUS   = 14'h1850;
  localparam logic [13:0] IDX_IRQ_MASK     = 14'h1851;

  // Port mirroring fields
  localparam int unsigned MIR_FILT_BIT = 8;
  localparam int unsigned SNIF_LSB     = 5;
  localparam int unsigned MIRP_LSB     = 2;
  localparam int unsigned RX_MIR_BIT   = 1;
  localparam int unsigned TX_MIR_BIT   = 0;

  // Ingress port type fields
  localparam int unsigned PTYPE_W         = 2;
  localparam logic [1:0]  TAG_DIRECT_MODE = 2'h3;

  // Broadcast throttle fields: per port a level byte then an enable bit
  localparam int unsigned BT_STRIDE    = 9;
  localparam int unsigned BT_LEVEL_W   = 8;
  localparam int unsigned BT_EN_OFS    = 8;
  localparam int unsigned BT_UNIT_SHFT = 6;

  // Rate configuration fields
  localparam int unsigned RATE_EN_BIT   = 0;
  localparam int unsigned RATE_MODE_LSB = 1;

  // Interrupt status layout
  localparam int unsigned IRQ_W         = 6;
  localparam int unsigned IRQ_DROP_LSB  = 0;
  localparam int unsigned IRQ_THROT_LSB = 3;

  // Reset values
  localparam logic [8:0]  RST_PORT_MIRROR  = 9'h000;
  localparam logic [5:0]  RST_PORT_TYPE    = 6'h00;
  localparam logic [26:0] RST_BCAST_THROT  = 27'h0080402;
  localparam logic [2:0]  RST_ADMIT_NONMEM = 3'h0;
  localparam logic [2:0]  RST_RATE_CFG     = 3'h0;
  localparam logic [5:0]  RST_IRQ          = 6'h00;

  // Throttle interval
  localparam int unsigned CLOCK_PERIOD_NS       = 40;
  localparam int unsigned BCAST_INTERVAL_NS     = 1720000;
  localparam int unsigned BCAST_INTERVAL_CYCLES =
    BCAST_INTERVAL_NS / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    RATE_PORT_PRIO = 2'b00,
    RATE_PORT_ONLY = 2'b01,
    RATE_PRIO_ONLY = 2'b10,
    RATE_RESERVED  = 2'b11
  } rate_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  src_port;
    logic [2:0]  prio;
    logic        bcast;
    logic [10:0] len;
    logic [2:0]  dest;
    logic [2:0]  tag_dest;
    logic        filtered;
    logic        non_member;
    logic        vlan_active;
    logic        meter_red;
  } pkt_desc_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] src_port;
    logic [2:0] dest;
    logic [2:0] mirror;
    logic       drop;
    logic       tag_directed;
    logic       meter_on;
    logic [4:0] meter_index;
    logic [2:0] filtered_count;
    logic       bcast_throttled;
  } fwd_decision_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] port;
  } tx_event_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] sniffer;
  } tx_mirror_t;

endpackage
